// >>> logic/dword_unit_params.svh
// Constants for the 64-bit add, leading-count and divide datapath.
// Assumes inclusion by the package only; the datapath modules use its macros without including it.
`ifndef DWORD_UNIT_PARAMS_SVH
`define DWORD_UNIT_PARAMS_SVH
`define OPC_REGULAR      6'h00
`define OPC_ADD_IMM_TRAP 6'h18
`define OPC_ADD_IMM_WRAP 6'h19
`define OPC_EXT_GROUP    6'h1c
`define FN_ADD_REG_WRAP  6'h2d
`define FN_DIV_SIGNED    6'h1e
`define FN_DIV_UNSIGNED  6'h1f
`define FN_CNT_ONES      6'h25
`define FN_CNT_ZEROS     6'h24
`define DIV_STEPS        7'h40
`endif

// >>> logic/dword_unit_pkg.sv
// Types shared by the datapath modules.
// Assumes the params header is on the include path.
package dword_unit_pkg;
`include "dword_unit_params.svh"
   typedef enum logic [0:0] {
      DIV_IDLE = 1'b0,
      DIV_RUN  = 1'b1
   } div_state_t;
endpackage

// >>> logic/lead_count.sv
// Leading-bit counter over a 64-bit word.
// Assumes the caller inverts the source for leading ones.
`timescale 1ns/1ps
`default_nettype none
module lead_count (
   input  wire logic [63:0] word_in,   // Scanned word
   output logic      [6:0]  zeros_out  // Leading zeros, 64 when zero
);
   always_comb begin
      zeros_out = 7'h40;
      for (int i = 0; i < 64; i++) begin
         if (word_in[i]) begin
            zeros_out = 7'(63 - i);
         end
      end
   end
endmodule
`default_nettype wire

// >>> logic/dword_unit.sv
// 64-bit add, leading-count and iterative divide datapath.
// Assumes decode presents one instruction per issue pulse with operands read.
`timescale 1ns/1ps
`default_nettype none
module dword_unit
   import dword_unit_pkg::*;
(
   input  wire logic        clk_in,          // Core clock, 125 MHz
   input  wire logic        rst_n_in,        // Async reset, active low
   input  wire logic        issue_in,        // Instruction valid pulse
   input  wire logic [31:0] instr_in,        // Instruction word
   input  wire logic [63:0] first_op_in,     // Value of first operand register
   input  wire logic [63:0] second_op_in,    // Value of second operand register
   input  wire logic        dword_ok_in,     // 64-bit ops permitted in mode
   input  wire logic        spec_read_in,    // Quotient/remainder read request
   output logic             wr_en_out,       // General register write pulse
   output logic      [4:0]  wr_index_out,    // Destination index
   output logic      [63:0] wr_data_out,     // Destination data
   output logic             ovf_exc_out,     // Integer overflow exception pulse
   output logic             resv_exc_out,    // Reserved instruction pulse
   output logic             busy_out,        // Divide in progress
   output logic             stall_out,       // Special register read stall
   output logic      [63:0] quotient_reg_out, // Quotient special register
   output logic      [63:0] remainder_reg_out // Remainder special register
);
   // ==========================================
   // Helpers
   // Sign fix-up for divide operands and results
   function automatic logic [63:0] cond_neg(input logic       neg,
                                            input logic [63:0] v);
      return neg ? -v : v;
   endfunction

   // ==========================================
   // Decode
   wire [5:0]  opc       = instr_in[31:26];
   wire [5:0]  fn        = instr_in[5:0];
   wire [4:0]  first_ix  = instr_in[25:21];
   wire [4:0]  second_ix = instr_in[20:16];
   wire [4:0]  dest_ix   = instr_in[15:11];
   wire        sa_zero   = (instr_in[10:6] == 5'h00);
   wire        is_regular = (opc == `OPC_REGULAR);
   wire        is_ext     = (opc == `OPC_EXT_GROUP);
   wire        op_addr    = is_regular && fn == `FN_ADD_REG_WRAP && sa_zero;
   wire        op_aimt    = (opc == `OPC_ADD_IMM_TRAP);
   wire        op_aimw    = (opc == `OPC_ADD_IMM_WRAP);
   wire        op_clo     = is_ext && fn == `FN_CNT_ONES && sa_zero;
   wire        op_clz     = is_ext && fn == `FN_CNT_ZEROS && sa_zero;
   wire        op_divs    = is_regular && fn == `FN_DIV_SIGNED;
   wire        op_divu    = is_regular && fn == `FN_DIV_UNSIGNED;
   wire        op_any     = op_addr | op_aimt | op_aimw | op_clo | op_clz | op_divs | op_divu;
   wire        blocked    = issue_in && op_any && !dword_ok_in;
   wire        go         = issue_in && dword_ok_in;

   // ==========================================
   // Add and count
   wire [63:0] imm_ext  = {{48{instr_in[15]}}, instr_in[15:0]};
   wire [63:0] addend   = op_addr ? second_op_in : imm_ext;
   wire [64:0] sum_ext  = {first_op_in[63], first_op_in} + {addend[63], addend};
   wire        ovf      = sum_ext[64] != sum_ext[63];
   wire        trap     = go && op_aimt && ovf;
   wire [6:0]  lz_count;
   lead_count u_lead_count (
      .word_in   (op_clo ? ~first_op_in : first_op_in),
      .zeros_out (lz_count)
   );
   // Count ops write the destination field; software keeps target equal
   wire        wr_now   = go && (op_addr || op_aimw || (op_aimt && !ovf) || op_clo || op_clz);
   wire [4:0]  wr_ix    = (op_aimt || op_aimw) ? second_ix : dest_ix;
   wire [63:0] wr_val   = (op_clo || op_clz) ? {57'h0, lz_count} : sum_ext[63:0];

   // ==========================================
   // Restoring divide, one quotient bit per cycle
   div_state_t  st_q, st_d;
   logic [63:0] rem_q, quo_q, dvs_q;
   logic [6:0]  cnt_q;
   logic        neg_q_q, neg_r_q;
   logic [63:0] rem_sr_q, quo_sr_q;
   wire         div_start = go && (op_divs || op_divu) && st_q == DIV_IDLE;
   wire         sgn       = op_divs;
   wire [63:0]  a_mag     = cond_neg(sgn && first_op_in[63], first_op_in);
   wire [63:0]  b_mag     = cond_neg(sgn && second_op_in[63], second_op_in);
   wire [64:0]  trial     = {rem_q, quo_q[63]} - {1'b0, dvs_q};
   wire         fits      = !trial[64];
   wire [63:0]  rem_nx    = fits ? trial[63:0] : {rem_q[62:0], quo_q[63]};
   wire [63:0]  quo_nx    = {quo_q[62:0], fits};
   wire         div_last  = st_q == DIV_RUN && cnt_q == 7'h01;
   // Zero divisor yields all-ones quotient, or 1 for a negative signed dividend; nothing traps
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         DIV_IDLE: if (div_start) st_d = DIV_RUN;
         DIV_RUN:  if (div_last) st_d = DIV_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q     <= DIV_IDLE;
         rem_q    <= 64'h0;
         quo_q    <= 64'h0;
         dvs_q    <= 64'h0;
         cnt_q    <= 7'h00;
         neg_q_q  <= 1'b0;
         neg_r_q  <= 1'b0;
         rem_sr_q <= 64'h0;
         quo_sr_q <= 64'h0;
      end else begin
         st_q <= st_d;
         if (div_start) begin
            rem_q   <= 64'h0;
            quo_q   <= a_mag;
            dvs_q   <= b_mag;
            cnt_q   <= `DIV_STEPS;
            neg_q_q <= sgn && (first_op_in[63] ^ second_op_in[63]);
            neg_r_q <= sgn && first_op_in[63];
         end else if (st_q == DIV_RUN) begin
            rem_q <= rem_nx;
            quo_q <= quo_nx;
            cnt_q <= cnt_q - 7'h01;
         end
         if (div_last) begin
            quo_sr_q <= cond_neg(neg_q_q, quo_nx);
            rem_sr_q <= cond_neg(neg_r_q, rem_nx);
         end
      end
   end

   // ==========================================
   // Registered outputs
   wire busy_d = (st_d == DIV_RUN);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_en_out    <= 1'b0;
         wr_index_out <= 5'h00;
         wr_data_out  <= 64'h0;
         ovf_exc_out  <= 1'b0;
         resv_exc_out <= 1'b0;
         busy_out     <= 1'b0;
         stall_out    <= 1'b0;
      end else begin
         wr_en_out    <= wr_now;
         wr_index_out <= wr_ix;
         wr_data_out  <= wr_val;
         ovf_exc_out  <= trap;
         resv_exc_out <= blocked;
         busy_out     <= busy_d;
         stall_out    <= spec_read_in && busy_d;
      end
   end
   assign quotient_reg_out  = quo_sr_q;
   assign remainder_reg_out = rem_sr_q;

   // ==========================================
   // Checks
   // Expected sums rebuilt from the raw fields, not from the adder above
   AST_TRAP_NO_WRITE: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      trap |=> ovf_exc_out && !wr_en_out)
      else $error("overflow wrote");

   AST_TRAP_SUM: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (go && op_aimt && !ovf) |=> wr_en_out && !ovf_exc_out &&
         wr_data_out == $past(first_op_in + {{48{instr_in[15]}}, instr_in[15:0]}))
      else $error("trap add wrote wrong sum");

   AST_WRAP_NO_TRAP: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (go && op_aimw) |=> wr_en_out && !ovf_exc_out &&
         wr_data_out == $past(first_op_in + {{48{instr_in[15]}}, instr_in[15:0]}))
      else $error("wrap add wrong");

   AST_REG_ADD: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (go && op_addr) |=> wr_en_out && wr_data_out == $past(first_op_in + second_op_in))
      else $error("reg add wrong");

   AST_CLZ_ZERO: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (go && op_clz && first_op_in == 64'h0) |=> wr_data_out == 64'h40)
      else $error("zero count of zero word wrong");

   AST_CLO_ONES: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (go && op_clo && &first_op_in) |=> wr_data_out == 64'h40)
      else $error("one count of full word wrong");

   AST_COUNT_INDEX: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (go && (op_clo || op_clz)) |=> wr_en_out && wr_index_out == $past(instr_in[15:11]))
      else $error("count wrote wrong index");

   AST_DIV_LEN: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      div_start |=> busy_out [*8])
      else $error("busy dropped");

   AST_DIV_DONE: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      div_start |-> ##[64:66] !busy_out)
      else $error("divide hung");

   AST_DIV_HOLD: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (st_q == DIV_RUN && !div_last) |=> $stable(quotient_reg_out) && $stable(remainder_reg_out))
      else $error("special register changed mid divide");

   AST_NO_DIV_EXC: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (go && (op_divs || op_divu)) |=> !ovf_exc_out)
      else $error("divide trapped");

   AST_RESV: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      blocked |=> resv_exc_out && !wr_en_out)
      else $error("resv missing");

   AST_STALL: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      stall_out |-> busy_out)
      else $error("stall while idle");

   COV_TRAP: cover property (@(posedge clk_in) trap);
   COV_DIV:  cover property (@(posedge clk_in) div_last);
   COV_STL:  cover property (@(posedge clk_in) stall_out);
   COV_RESV: cover property (@(posedge clk_in) blocked);
   COV_REFUSED: cover property (@(posedge clk_in) go && (op_divs || op_divu) && st_q == DIV_RUN);
endmodule
`default_nettype wire

// >>> verification/issue_model.sv
// Issue-side model: hands one instruction per request to the datapath.
// Assumes the bench raises go_in for exactly one cycle per instruction.
`timescale 1ns/1ps
`default_nettype none
module issue_model (
   input  wire logic        go_in,      // Request from bench
   input  wire logic [31:0] word_in,    // Instruction to issue
   input  wire logic [63:0] a_in,       // First operand value
   input  wire logic [63:0] b_in,       // Second operand value
   output logic             issue_out,  // Issue pulse
   output logic      [31:0] instr_out,  // Issued word
   output logic      [63:0] first_out,  // First operand bus
   output logic      [63:0] second_out  // Second operand bus
);
   wire logic cnt_op = (word_in[31:26] == 6'h1c);
   assign issue_out  = go_in;
   // Count ops carry the destination in the target field too
   assign instr_out  = cnt_op ? {word_in[31:21], word_in[15:11], word_in[15:0]} : word_in;
   // Idle buses flip so a stale value never passes as valid
   assign first_out  = go_in ? a_in : ~a_in;
   assign second_out = go_in ? b_in : ~b_in;
endmodule
`default_nettype wire

// >>> verification/dword_unit_tb.sv
// Self-checking bench for the 64-bit add, count and divide datapath.
// Assumes the issue model sits between bench and design.
`timescale 1ns/1ps
`default_nettype none
module dword_unit_tb;
   import dword_unit_pkg::*;
   logic        clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        go = 1'b0;
   logic        ok = 1'b1;
   logic        rd_req = 1'b0;
   logic [31:0] word = 32'h0;
   logic [31:0] seed = 32'h0001_7679;
   logic [63:0] a = 64'h0;
   logic [63:0] b = 64'h0;
   int          mismatches = 0;
   int          n_compared = 0;
   wire logic        issue, wr_en, ovf, resv, busy, stall;
   wire logic [31:0] instr;
   wire logic [4:0]  idx;
   wire logic [63:0] fop, sop, data, quo, rem;
   always #4 clk_in = ~clk_in;
   issue_model pm_u (.go_in(go), .word_in(word), .a_in(a), .b_in(b), .issue_out(issue),
      .instr_out(instr), .first_out(fop), .second_out(sop));
   dword_unit dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .issue_in(issue), .instr_in(instr),
      .first_op_in(fop), .second_op_in(sop), .dword_ok_in(ok), .spec_read_in(rd_req),
      .wr_en_out(wr_en), .wr_index_out(idx), .wr_data_out(data), .ovf_exc_out(ovf),
      .resv_exc_out(resv), .busy_out(busy), .stall_out(stall), .quotient_reg_out(quo),
      .remainder_reg_out(rem));
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic void rnd(output logic [63:0] v);
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      v[63:32] = seed;
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      v[31:0] = seed;
   endfunction
   // Returns {quotient, remainder}
   function automatic logic [127:0] div_expect(input logic uns, input logic [63:0] x, y);
      logic [63:0] q;
      logic [63:0] r;
      if (uns) begin
         q = x / y;
         r = x % y;
      end else begin
         q = $signed(x) / $signed(y);
         r = $signed(x) % $signed(y);
      end
      return {q, r};
   endfunction
   task automatic put(input logic [31:0] w, input logic [63:0] x, input logic [63:0] y);
      @(negedge clk_in);
      word = w;
      a = x;
      b = y;
      go = 1'b1;
      @(negedge clk_in);
      go = 1'b0;
   endtask
   // Returns {write, overflow, data}
   function automatic logic [65:0] expect_of(input logic [31:0] w, input logic [63:0] x, y);
      logic [64:0] s;
      logic [63:0] imm;
      logic [6:0]  n;
      imm = {{48{w[15]}}, w[15:0]};
      s = {x[63], x} + {imm[63], imm};
      n = 7'h0;
      for (int i = 63; i >= 0 && x[i] == w[0]; i--) n++;
      case (w[31:26])
         6'h00: return {2'b10, x + y};
         6'h19: return {2'b10, x + imm};
         6'h18: return {~(s[64] ^ s[63]), s[64] ^ s[63], s[63:0]};
         default: return {2'b10, 57'h0, n};
      endcase
   endfunction
   initial begin
      logic [63:0] r, x, y;
      logic [31:0] w;
      logic [65:0] e;
      logic [5:0]  ops [5];
      logic [127:0] d;
      ops = '{6'h00, 6'h19, 6'h18, 6'h1c, 6'h1c};
      repeat (20) @(posedge clk_in);
      @(negedge clk_in) rst_n_in = 1'b1;
      for (int k = 0; k < 5; k++) for (int i = 0; i < 40; i++) begin
         rnd(r);
         rnd(x);
         rnd(y);
         w = {ops[k], r[25:0]};
         if (k == 0) w[10:0] = 11'h02d;
         if (k >= 3) w[10:0] = {5'h00, 5'h12, k[0]};
         if (i == 0) x = 64'hffff_ffff_ffff_ffff;
         if (i == 1) x = 64'h0;
         if (i == 2 || i == 3) w[15] = i[0];
         if (i == 2) x = 64'h7fff_ffff_ffff_ffff;
         if (i == 3) x = 64'h8000_0000_0000_0000;
         ok = (i != 4);
         e = expect_of(w, x, y);
         put(w, x, y);
         chk(wr_en, e[65] & ok);
         chk(ovf, e[64] & ok);
         chk(resv, !ok);
         if (e[65] && ok) chk(data, e[63:0]);
         if (ok) chk(idx, (k == 1 || k == 2) ? w[20:16] : w[15:11]);
      end
      ok = 1'b1;
      for (int i = 0; i < 6; i++) begin
         rnd(x);
         rnd(y);
         y[5] = 1'b0;
         y[6] = 1'b1;
         w = {6'h00, 20'h0, 5'h0f, i[0]};
         put(w, x, y);
         rd_req = 1'b1;
         chk(busy, 1'b1);
         put(w, y, x);
         chk(stall, 1'b1);
         for (int c = 0; c < 80 && busy === 1'b1; c++) @(negedge clk_in);
         rd_req = 1'b0;
         chk(busy, 1'b0);
         chk(ovf | resv, 1'b0);
         d = div_expect(i[0], x, y);
         chk(quo, d[127:64]);
         chk(rem, d[63:0]);
      end
      conclude();
   end
   initial begin
      #200000;
      mismatches++;
      conclude();
   end
endmodule
`default_nettype wire
